// ===== rtl/tnacq_fsm.sv
// Functional notes
// - Entering system-info wait turns on control-channel receive and overhead messages.
// - No system-info within 5 s: turn both off, back to channel selection.
// - Other control-channel messages during system-info wait are dropped unacted.
// - Revision outside inclusive floor..ceiling: turn both off, back to channel selection.
// - Accepted revision loads terminal time from block's low twelve digits.
// - On the same edge as the time load, pulse network-found and go idle.
// - Pilot search gives up after 60 s.
// - Protocol subtype reported is 0x0000.
// - Activate moves idle to channel selection; ignored elsewhere.
// - Deactivate ignored in idle; elsewhere returns to idle.
// - Channel selected enters pilot acquisition on that channel.
// - Pilot found enters system-info wait; pilot limit expiry returns to selection.
`timescale 1ns/100ps
module tnacq_fsm
    import tnacq_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES // Core clock cycles per timeout tick
)
(
    input wire logic core_clk, // 50 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic activate, // Upper-layer activate pulse
    input wire logic deactivate, // Upper-layer deactivate pulse
    input wire logic chan_selected, // Channel chosen pulse
    input wire logic pilot_found, // Pilot acquired pulse
    input wire logic msg_valid, // Control-channel message strobe
    input wire logic msg_is_sysinfo, // Message is a system-info block
    input wire tnacq_sysinfo_s sys_info_block, // System-info fields
    input wire logic [REV_W-1:0] own_rev, // Terminal revision number
    output tnacq_lower_cmd_s lower_cmd, // Lower function command pulses
    output logic net_found_ind, // Network acquired pulse
    output logic [TIME_W-1:0] term_time, // Loaded terminal time
    output logic [15:0] proto_subtype, // Protocol subtype
    output tnacq_state_e state_out, // Current state
    output logic msg_dropped // Pulse for a discarded message
);
    // ********************************************************************
    // Helper functions
    // ********************************************************************
    function automatic logic rev_ok(input logic [REV_W-1:0] r, input logic [REV_W-1:0] lo,
                                    input logic [REV_W-1:0] hi);
        rev_ok = (r >= lo) && (r <= hi);
    endfunction

    // Twelve decimal digits fit below 10^12
    function automatic logic [TIME_W-1:0] low12_digits(input logic [TIME_W-1:0] t);
        low12_digits = TIME_W'(t % 64'h000000E8D4A51000);
    endfunction

    // ********************************************************************
    // State machine
    // ********************************************************************
    tnacq_state_e state;
    tnacq_state_e next_state;
    logic [PRESC_W-1:0] presc;
    logic [TMO_W-1:0] tmo;
    logic tick;
    logic sys_rx;
    logic accept;
    logic tmo_sys;
    logic tmo_pilot;
    logic entering;

    assign tick = (presc == PRESC_W'(TICK_LEN - 1));
    assign sys_rx = msg_valid && msg_is_sysinfo;
    assign accept = rev_ok(own_rev, sys_info_block.rev_floor, sys_info_block.rev_ceiling);
    assign tmo_sys = tick && (tmo == TMO_W'(SYSINFO_WAIT_TICKS - 1));
    assign tmo_pilot = tick && (tmo == TMO_W'(PILOT_WAIT_TICKS - 1));
    assign entering = (next_state != state);

    // Next-state decode
    always_comb begin
        next_state = state;
        unique case (state)
            TNACQ_IDLE: begin
                if (activate) next_state = TNACQ_CHAN_SEL;
            end
            TNACQ_CHAN_SEL: begin
                if (deactivate) next_state = TNACQ_IDLE;
                else if (chan_selected) next_state = TNACQ_PILOT;
            end
            TNACQ_PILOT: begin
                if (deactivate) next_state = TNACQ_IDLE;
                else if (pilot_found) next_state = TNACQ_SYSINFO;
                else if (tmo_pilot) next_state = TNACQ_CHAN_SEL;
            end
            TNACQ_SYSINFO: begin
                if (deactivate) next_state = TNACQ_IDLE;
                else if (sys_rx) next_state = accept ? TNACQ_IDLE : TNACQ_CHAN_SEL;
                else if (tmo_sys) next_state = TNACQ_CHAN_SEL;
            end
            default: next_state = TNACQ_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (rst) state <= TNACQ_IDLE;
        else state <= next_state;
    end

    // ********************************************************************
    // Timeout prescaler and counter
    // ********************************************************************
    // Prescaler restarts with each state entry so the limit is never short
    always_ff @(posedge core_clk) begin
        if (rst || entering || tick) presc <= '0;
        else presc <= presc + PRESC_W'(1);
    end

    // Tick counter restarts on entry
    always_ff @(posedge core_clk) begin
        if (rst || entering) tmo <= '0;
        else if (tick) tmo <= tmo + TMO_W'(1);
    end

    // ********************************************************************
    // Lower-function commands
    // ********************************************************************
    // On pulses on entry to system-info wait; off pulses on leaving it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lower_cmd <= '0;
        end else begin
            lower_cmd.ctrl_chan_on_cmd <= entering && next_state == TNACQ_SYSINFO;
            lower_cmd.ovh_msg_on_cmd <= entering && next_state == TNACQ_SYSINFO;
            lower_cmd.ctrl_chan_off_cmd <= state == TNACQ_SYSINFO && next_state != TNACQ_SYSINFO;
            lower_cmd.ovh_msg_off_cmd <= state == TNACQ_SYSINFO && next_state != TNACQ_SYSINFO;
        end
    end

    // ********************************************************************
    // System-info acceptance
    // ********************************************************************
    logic take;
    assign take = state == TNACQ_SYSINFO && !deactivate && sys_rx && accept;

    // Terminal time load
    always_ff @(posedge core_clk) begin
        if (rst) term_time <= '0;
        else if (take) term_time <= low12_digits(sys_info_block.sf_time);
    end

    // Network-found pulse, same edge as the time load takes effect
    always_ff @(posedge core_clk) begin
        if (rst) net_found_ind <= 1'b0;
        else net_found_ind <= take;
    end

    // Non-sysinfo messages while waiting are discarded
    always_ff @(posedge core_clk) begin
        if (rst) msg_dropped <= 1'b0;
        else msg_dropped <= state == TNACQ_SYSINFO && msg_valid && !msg_is_sysinfo;
    end

    // Status outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            proto_subtype <= PROTO_SUBTYPE_DEFAULT;
            state_out <= TNACQ_IDLE;
        end else begin
            proto_subtype <= PROTO_SUBTYPE_DEFAULT;
            state_out <= next_state;
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    sysinfo_on_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == TNACQ_PILOT && pilot_found && !deactivate) |=> lower_cmd.ctrl_chan_on_cmd && lower_cmd.ovh_msg_on_cmd)
        else $error("on commands missing on sysinfo entry");
    sysinfo_tmo_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == TNACQ_SYSINFO && tmo_sys && !sys_rx && !deactivate)
        |=> state == TNACQ_CHAN_SEL && lower_cmd.ctrl_chan_off_cmd && lower_cmd.ovh_msg_off_cmd)
        else $error("sysinfo timeout not handled");
    drop_msg_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == TNACQ_SYSINFO && msg_valid && !msg_is_sysinfo && !deactivate && !tmo_sys)
        |=> state == TNACQ_SYSINFO && msg_dropped)
        else $error("other message acted on");
    rev_reject_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == TNACQ_SYSINFO && sys_rx && !deactivate
            && (own_rev < sys_info_block.rev_floor || own_rev > sys_info_block.rev_ceiling))
        |=> state == TNACQ_CHAN_SEL && !net_found_ind
            && lower_cmd.ctrl_chan_off_cmd && lower_cmd.ovh_msg_off_cmd)
        else $error("out of range revision accepted");
    time_load_a: assert property (@(posedge core_clk) disable iff (rst)
        take |=> term_time == low12_digits($past(sys_info_block.sf_time)))
        else $error("terminal time not loaded");
    found_idle_a: assert property (@(posedge core_clk) disable iff (rst)
        net_found_ind |-> state == TNACQ_IDLE && $past(state) == TNACQ_SYSINFO)
        else $error("found pulse without idle return");
    pilot_tmo_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == TNACQ_PILOT && tmo_pilot && !pilot_found && !deactivate) |=> state == TNACQ_CHAN_SEL)
        else $error("pilot limit not handled");
    pilot_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == TNACQ_PILOT && !pilot_found && !deactivate && tmo != TMO_W'(PILOT_WAIT_TICKS - 1))
        |=> state == TNACQ_PILOT)
        else $error("pilot search left early");
    sysinfo_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == TNACQ_SYSINFO && !sys_rx && !deactivate && tmo != TMO_W'(SYSINFO_WAIT_TICKS - 1))
        |=> state == TNACQ_SYSINFO)
        else $error("sysinfo wait left early");
    pilot_found_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == TNACQ_PILOT && pilot_found && !deactivate) |=> state == TNACQ_SYSINFO)
        else $error("pilot found not taken");
    tick_range_a: assert property (@(posedge core_clk) disable iff (rst)
        presc <= PRESC_W'(TICK_LEN - 1))
        else $error("prescaler overran");
    subtype_a: assert property (@(posedge core_clk) disable iff (rst)
        proto_subtype == 16'h0000)
        else $error("subtype not default");
    act_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == TNACQ_IDLE && activate) |=> state == TNACQ_CHAN_SEL)
        else $error("activate not taken");
    deact_a: assert property (@(posedge core_clk) disable iff (rst)
        (state != TNACQ_IDLE && deactivate) |=> state == TNACQ_IDLE)
        else $error("deactivate not taken");
    chan_sel_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == TNACQ_CHAN_SEL && chan_selected && !deactivate) |=> state == TNACQ_PILOT)
        else $error("channel select not taken");
    restart_a: assert property (@(posedge core_clk) disable iff (rst)
        (state != $past(state)) |-> tmo == '0 && presc == '0)
        else $error("timeout not restarted");
endmodule

// ===== rtl/tnacq_pkg.sv
package tnacq_pkg;
    // ********************************************************************
    // Timing constants
    // ********************************************************************
    localparam int CLK_HZ = 50000000;
    localparam int SYSINFO_WAIT_S = 5;
    localparam int PILOT_WAIT_S = 60;
    // Prescaler: one tick per millisecond of core clock
    localparam int TICK_MS_HZ = 1000;
    localparam int TICK_CYCLES = CLK_HZ / TICK_MS_HZ;
    localparam int SYSINFO_WAIT_TICKS = SYSINFO_WAIT_S * TICK_MS_HZ;
    localparam int PILOT_WAIT_TICKS = PILOT_WAIT_S * TICK_MS_HZ;
    localparam int PRESC_W = 16;
    localparam int TMO_W = 17;

    // ********************************************************************
    // Field widths and constants
    // ********************************************************************
    localparam int REV_W = 8;
    localparam int TIME_W = 40;
    localparam logic [15:0] PROTO_SUBTYPE_DEFAULT = 16'h0000;
    localparam logic [REV_W-1:0] OWN_REV_DEFAULT = 8'h01;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [3:0] {
        TNACQ_IDLE = 4'b0001,
        TNACQ_CHAN_SEL = 4'b0010,
        TNACQ_PILOT = 4'b0100,
        TNACQ_SYSINFO = 4'b1000
    } tnacq_state_e;

    typedef struct packed {
        logic [REV_W-1:0] rev_floor;
        logic [REV_W-1:0] rev_ceiling;
        logic [TIME_W-1:0] sf_time;
    } tnacq_sysinfo_s;

    typedef struct packed {
        logic ctrl_chan_on_cmd;
        logic ctrl_chan_off_cmd;
        logic ovh_msg_on_cmd;
        logic ovh_msg_off_cmd;
    } tnacq_lower_cmd_s;
endpackage

// ===== verification/tnacq_lower_model.sv
`timescale 1ns/100ps
// ********************************************************************
// Control-channel and overhead-message functions on the lower side
// ********************************************************************
module tnacq_lower_model
    import tnacq_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire logic rst, // Synchronous reset, active high
    input wire tnacq_lower_cmd_s lower_cmd, // Command pulses from the block
    output logic msg_valid, // Message strobe
    output logic msg_is_sysinfo, // Message is a system-info block
    output tnacq_sysinfo_s sys_info_block, // Block fields
    output logic chan_on, // Receive function active
    output logic ovh_on // Overhead function active
);
    // Follow on and off commands of both functions
    always_ff @(posedge core_clk) begin
        if (rst) begin
            chan_on <= 1'b0;
            ovh_on <= 1'b0;
        end else begin
            if (lower_cmd.ctrl_chan_on_cmd) chan_on <= 1'b1;
            if (lower_cmd.ctrl_chan_off_cmd) chan_on <= 1'b0;
            if (lower_cmd.ovh_msg_on_cmd) ovh_on <= 1'b1;
            if (lower_cmd.ovh_msg_off_cmd) ovh_on <= 1'b0;
        end
    end

    // One message for one cycle; nothing arrives while receive is off
    task automatic send(input logic is_sys, input tnacq_sysinfo_s blk);
        @(negedge core_clk);
        msg_valid = chan_on;
        msg_is_sysinfo = is_sys;
        sys_info_block = blk;
        @(negedge core_clk);
        msg_valid = 1'b0;
        msg_is_sysinfo = ~is_sys; // Released lines show no stale value
        sys_info_block = ~blk;
    endtask

    // Idle lines at time zero
    initial begin
        msg_valid = 1'b0;
        msg_is_sysinfo = 1'b0;
        sys_info_block = '0;
    end
endmodule

// ===== verification/tb_terminal_network_acquisition_fsm.sv
`timescale 1ns/100ps
module tb_terminal_network_acquisition_fsm
    import tnacq_pkg::*;
;
    logic core_clk, rst, activate, deactivate, chan_selected, pilot_found, msg_valid, msg_is_sysinfo;
    logic net_found_ind, msg_dropped, chan_on, ovh_on, ok;
    logic [REV_W-1:0] own_rev, lo, hi;
    logic [TIME_W-1:0] term_time, exp_time;
    logic [15:0] proto_subtype;
    tnacq_sysinfo_s blk, tx;
    tnacq_lower_cmd_s lower_cmd;
    tnacq_state_e state_out;
    int failures = 0;
    int total_checks = 0;
    localparam int TB_TICK = 1; // One-cycle ticks keep both timeouts inside the run

    // ********************************************************************
    // Clock, design and lower-side model
    // ********************************************************************
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    tnacq_fsm #(.TICK_LEN(TB_TICK)) DUT (.core_clk(core_clk), .rst(rst), .activate(activate), .deactivate(deactivate),
        .chan_selected(chan_selected), .pilot_found(pilot_found), .msg_valid(msg_valid),
        .msg_is_sysinfo(msg_is_sysinfo), .sys_info_block(blk), .own_rev(own_rev), .lower_cmd(lower_cmd),
        .net_found_ind(net_found_ind), .term_time(term_time), .proto_subtype(proto_subtype),
        .state_out(state_out), .msg_dropped(msg_dropped));
    tnacq_lower_model lower (.core_clk(core_clk), .rst(rst), .lower_cmd(lower_cmd), .msg_valid(msg_valid),
        .msg_is_sysinfo(msg_is_sysinfo), .sys_info_block(blk), .chan_on(chan_on), .ovh_on(ovh_on));

    // ********************************************************************
    // Shared tasks
    // ********************************************************************
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // Pulse 0 activate, 1 deactivate, 2 channel chosen, 3 pilot found
    task automatic pulse(input int which);
        @(negedge core_clk);
        {activate, deactivate, chan_selected, pilot_found} = 4'h8 >> which;
        @(negedge core_clk);
        {activate, deactivate, chan_selected, pilot_found} = 4'h0;
    endtask

    // Compare all event outputs against the model's expectation
    task automatic expect_out(input tnacq_state_e st, input logic [3:0] cmd, input logic nf, input logic dr);
        chk("state_out", state_out, st);
        chk("lower_cmd", lower_cmd, cmd);
        chk("net_found_ind", net_found_ind, nf);
        chk("msg_dropped", msg_dropped, dr);
        chk("term_time", term_time, exp_time);
    endtask

    // Wait until the cycle before a timeout of n ticks expires
    task automatic wait_ticks(input int n);
        repeat (n * TB_TICK - 1) @(negedge core_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (100000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial begin
        {rst, activate, deactivate, chan_selected, pilot_found} = 5'h10;
        own_rev = 8'h01;
        exp_time = '0;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        void'($urandom(32'he258f2f4));
        chk("proto_subtype", proto_subtype, 16'h0000);
        pulse(1);
        expect_out(TNACQ_IDLE, 4'h0, 1'b0, 1'b0);
        pulse(0);
        pulse(0);
        expect_out(TNACQ_CHAN_SEL, 4'h0, 1'b0, 1'b0);
        pulse(3);
        pulse(2);
        expect_out(TNACQ_PILOT, 4'h0, 1'b0, 1'b0);
        pulse(1);
        expect_out(TNACQ_IDLE, 4'h0, 1'b0, 1'b0);
        $display("test commands done");
        for (int i = 0; i < 10; i++) begin
            lo = 8'h01 + 8'($urandom % 127);
            hi = lo + 8'($urandom % 127);
            own_rev = (i == 0) ? lo : (i == 1) ? hi : (i == 2) ? lo - 8'h01 : (i == 3) ? hi + 8'h01 : 8'($urandom);
            ok = (own_rev >= lo) && (own_rev <= hi);
            pulse(0);
            pulse(2);
            pulse(3);
            expect_out(TNACQ_SYSINFO, 4'hA, 1'b0, 1'b0);
            lower.send(1'b0, '1);
            expect_out(TNACQ_SYSINFO, 4'h0, 1'b0, 1'b1);
            if (i == 9) begin
                pulse(1);
                expect_out(TNACQ_IDLE, 4'h5, 1'b0, 1'b0);
            end else begin
                tx = {lo, hi, 8'($urandom), 32'($urandom)};
                lower.send(1'b1, tx);
                if (ok) exp_time = 40'(64'(tx.sf_time) % 64'h000000E8D4A51000);
                expect_out(ok ? TNACQ_IDLE : TNACQ_CHAN_SEL, 4'h5, ok, 1'b0);
                @(negedge core_clk);
                chk("net_found_ind", net_found_ind, 1'b0);
                chk("chan_on", {chan_on, ovh_on}, 2'h0);
                if (!ok) pulse(1);
            end
            $display("test revision case %0d done", i);
        end
        // Both waits expire exactly when their tick count runs out
        pulse(0);
        pulse(2);
        wait_ticks(PILOT_WAIT_TICKS);
        chk("pilot_wait", state_out, TNACQ_PILOT);
        @(negedge core_clk);
        expect_out(TNACQ_CHAN_SEL, 4'h0, 1'b0, 1'b0);
        pulse(2);
        pulse(3);
        wait_ticks(SYSINFO_WAIT_TICKS);
        chk("sysinfo_wait", state_out, TNACQ_SYSINFO);
        @(negedge core_clk);
        expect_out(TNACQ_CHAN_SEL, 4'h5, 1'b0, 1'b0);
        pulse(1);
        expect_out(TNACQ_IDLE, 4'h0, 1'b0, 1'b0);
        chk("chan_on", {chan_on, ovh_on}, 2'h0);
        $display("test timeouts done");
        tally_and_finish();
    end
endmodule
